// >>> hw/ct16_pkg.sv
/*
 * Package for the cascaded 16-bit timer: register offsets, field
 * positions, reset values, mode and clock-source codes and carriers.
 * Assumes a plain register port with read data one cycle after the strobe.
 */
package ct16_pkg;

  // Register offsets on the plain register port.
  localparam logic [3:0] ADDR_PERIOD_LO = 4'h0;
  localparam logic [3:0] ADDR_PERIOD_HI = 4'h1;
  localparam logic [3:0] ADDR_DUTY_LO   = 4'h2;
  localparam logic [3:0] ADDR_DUTY_HI   = 4'h3;
  localparam logic [3:0] ADDR_CTRL      = 4'h4;
  localparam logic [3:0] ADDR_CNT_LO    = 4'h5;
  localparam logic [3:0] ADDR_CNT_HI    = 4'h6;

  // Control register field positions.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RUN_BIT  = 3;
  localparam int CTRL_SRC_LSB  = 4;
  localparam int CTRL_FFIV_BIT = 7;

  // Reset values.
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [15:0] PERIOD_RESET = 16'hffff;
  localparam logic [15:0] DUTY_RESET   = 16'hffff;

  // Operating modes held in the control register.
  localparam logic [2:0] MODE_EVENT  = 3'h0;
  localparam logic [2:0] MODE_PWM    = 3'h1;
  localparam logic [2:0] MODE_PULSE  = 3'h2;
  localparam logic [2:0] MODE_WARMUP = 3'h3;

  // Count sources: internal prescaled tick or external pin edge.
  localparam logic [2:0] SRC_EXT  = 3'h0;
  localparam logic [2:0] SRC_TICK = 3'h1;

  // Prescaler for the internal tick, in system clock cycles.
  localparam logic [7:0] PRESCALE_DIV = 8'h08;

  typedef struct packed {
    logic       we;
    logic       re;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ct16_bus_t;

  typedef struct packed {
    logic ffiv;
    logic [2:0] src;
    logic run;
    logic [2:0] mode;
  } ct16_ctrl_t;

endpackage

// >>> hw/ct16_timer.sv
/*
 * Cascaded 16-bit timer: event counter, 16-bit PWM, pulse generator and
 * warm-up counter, with one output flip-flop and a cascade interrupt.
 * Assumes all inputs, including the event pin, are synchronous to I_CLK.
 */
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Event mode counts falling edges of the event input pin.
// - After run, period match interrupts and clears; counting resumes.
// - Event-mode period registers are unbuffered and act at once.
// - PWM toggles on duty match, toggles and clears on overflow, interrupts.
// - PWM and pulse modes count internal tick or external pin edges.
// - Flip-flop loads initial value, resets to zero; pin drives its inverse.
// - PWM duty buffered: loads on interrupt if running, else at once.
// - Duty read while PWM runs returns the active value.
// - Stopping holds the pin level; initial value changes only after stop.
// - Pulse mode toggles on duty match, toggles and clears on period match.
// - Pulse-mode duty and period are unbuffered.
// - Warm-up mode times oscillator settling in either direction.
// - Warm-up compares only the upper period byte.
module ct16_timer (
  // Clock and reset.
  input  wire logic       I_CLK,
  input  wire logic       I_ARST_N,
  // Register port.
  input  wire logic       I_WE,
  input  wire logic       I_RE,
  input  wire logic [3:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  output logic      [7:0] O_RDATA,
  // External pins.
  input  wire logic       I_EVENT_PIN,
  output logic            O_PWM_N,
  output logic            O_PULSE_N,
  output logic            O_IRQ
);

  ////////////////////////////////////////////////////////////////////////
  // Register port and control state.

  ct16_pkg::ct16_bus_t  bus;
  ct16_pkg::ct16_ctrl_t ctrl;

  logic [7:0]  ctrl_ff;
  logic [15:0] period_ff;
  logic [15:0] duty_wr_ff;
  logic [15:0] duty_act_ff;
  logic [15:0] cnt_ff;
  logic        ff_ff;
  logic        pin_d_ff;
  logic [7:0]  pre_ff;
  logic [7:0]  rdata_ff;
  logic        irq_ff;
  logic        duty_pend_ff;

  assign bus  = '{we: I_WE, re: I_RE, addr: I_ADDR, wdata: I_WDATA};
  assign ctrl = ctrl_ff;

  wire wr_ctrl = bus.we && (bus.addr == ct16_pkg::ADDR_CTRL);
  wire wr_plo  = bus.we && (bus.addr == ct16_pkg::ADDR_PERIOD_LO);
  wire wr_phi  = bus.we && (bus.addr == ct16_pkg::ADDR_PERIOD_HI);
  wire wr_dlo  = bus.we && (bus.addr == ct16_pkg::ADDR_DUTY_LO);
  wire wr_dhi  = bus.we && (bus.addr == ct16_pkg::ADDR_DUTY_HI);

  wire       running  = ctrl.run;
  wire       is_pwm   = (ctrl.mode == ct16_pkg::MODE_PWM);
  wire       is_pulse = (ctrl.mode == ct16_pkg::MODE_PULSE);
  wire       is_warm  = (ctrl.mode == ct16_pkg::MODE_WARMUP);
  wire       is_event = (ctrl.mode == ct16_pkg::MODE_EVENT);
  wire       out_mode = is_pwm || is_pulse;

  // Duty readback shows the active value while PWM runs.
  wire [15:0] duty_rd = (is_pwm && running) ? duty_act_ff : duty_wr_ff;

  logic [7:0] rd_sel;
  always_comb begin
    if (bus.addr == ct16_pkg::ADDR_PERIOD_LO) begin
      rd_sel = period_ff[7:0];
    end else if (bus.addr == ct16_pkg::ADDR_PERIOD_HI) begin
      rd_sel = period_ff[15:8];
    end else if (bus.addr == ct16_pkg::ADDR_DUTY_LO) begin
      rd_sel = duty_rd[7:0];
    end else if (bus.addr == ct16_pkg::ADDR_DUTY_HI) begin
      rd_sel = duty_rd[15:8];
    end else if (bus.addr == ct16_pkg::ADDR_CTRL) begin
      rd_sel = ctrl_ff;
    end else if (bus.addr == ct16_pkg::ADDR_CNT_LO) begin
      rd_sel = cnt_ff[7:0];
    end else if (bus.addr == ct16_pkg::ADDR_CNT_HI) begin
      rd_sel = cnt_ff[15:8];
    end else begin
      rd_sel = 8'h00;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rdata_ff <= 8'h00;
    end else if (bus.re) begin
      rdata_ff <= rd_sel;
    end
  end

  assign O_RDATA = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // Count enable: internal prescaled tick or falling pin edge.

  wire pre_wrap = (pre_ff == ct16_pkg::PRESCALE_DIV - 8'h01);
  wire pin_fall = pin_d_ff && !I_EVENT_PIN;
  wire use_ext  = is_event || (ctrl.src == ct16_pkg::SRC_EXT);
  wire tick     = use_ext ? pin_fall : pre_wrap;
  wire step     = running && tick;

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pre_ff   <= 8'h00;
      pin_d_ff <= 1'b1;
    end else begin
      pre_ff   <= pre_wrap ? 8'h00 : pre_ff + 8'h01;
      pin_d_ff <= I_EVENT_PIN;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Match detection and counter.

  // Warm-up compares only the upper byte of the period.
  wire per_hit  = is_warm ? (cnt_ff[15:8] == period_ff[15:8])
                          : (cnt_ff == period_ff);
  wire duty_hit = (cnt_ff == duty_act_ff);
  wire ovf      = (cnt_ff == 16'hffff);

  // Clear event per mode: overflow in PWM, period match elsewhere.
  wire clr_evt  = step && (is_pwm ? ovf : per_hit);
  wire tog_duty = step && out_mode && duty_hit && !clr_evt;
  wire tog_clr  = clr_evt && out_mode;
  wire [15:0] nxt_cnt = clr_evt ? 16'h0000 : cnt_ff + 16'h0001;

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cnt_ff <= 16'h0000;
      irq_ff <= 1'b0;
    end else begin
      if (step) begin
        cnt_ff <= nxt_cnt;
      end
      irq_ff <= clr_evt;
    end
  end

  assign O_IRQ = irq_ff;

  ////////////////////////////////////////////////////////////////////////
  // Registers: period unbuffered; duty buffered only in running PWM.

  wire ctrl_starts = wr_ctrl && bus.wdata[ct16_pkg::CTRL_RUN_BIT];
  wire duty_load   = (is_pwm && running) ? (clr_evt && duty_pend_ff)
                                         : 1'b0;

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ctrl_ff      <= ct16_pkg::CTRL_RESET;
      period_ff    <= ct16_pkg::PERIOD_RESET;
      duty_wr_ff   <= ct16_pkg::DUTY_RESET;
      duty_act_ff  <= ct16_pkg::DUTY_RESET;
      duty_pend_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= bus.wdata;
      end
      if (wr_plo) begin
        period_ff[7:0] <= bus.wdata;
      end
      if (wr_phi) begin
        period_ff[15:8] <= bus.wdata;
      end
      if (wr_dlo) begin
        duty_wr_ff[7:0] <= bus.wdata;
      end
      if (wr_dhi) begin
        duty_wr_ff[15:8] <= bus.wdata;
      end
      // Buffered copy moves on the interrupt, else follows at once.
      if (duty_load) begin
        duty_act_ff <= duty_wr_ff;
      end else if (!(is_pwm && running)) begin
        duty_act_ff <= duty_wr_ff;
      end
      // A new write wins over the load that consumes the pending flag.
      if (wr_dlo || wr_dhi) begin
        duty_pend_ff <= 1'b1;
      end else if (duty_load) begin
        duty_pend_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output flip-flop and inverted pins.

  // Initial value loads only while stopped and not on the stop write.
  wire ff_init = wr_ctrl && !running && !ctrl_starts
                 && !ctrl_ff[ct16_pkg::CTRL_RUN_BIT];
  wire ff_load_start = ctrl_starts && !running;
  wire nxt_ff = bus.wdata[ct16_pkg::CTRL_FFIV_BIT];

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ff_ff <= 1'b0;
    end else if (ff_init || ff_load_start) begin
      ff_ff <= nxt_ff;
    end else if (tog_duty || tog_clr) begin
      ff_ff <= !ff_ff;
    end
  end

  // Pins show the inverse; stopping freezes the flip-flop.
  assign O_PWM_N   = !ff_ff;
  assign O_PULSE_N = !ff_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  irq_pulse_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    O_IRQ |=> !O_IRQ)
    else $error("interrupt longer than one cycle");

  clear_irq_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    clr_evt |=> (O_IRQ && cnt_ff == 16'h0000))
    else $error("clear without interrupt");

  event_edge_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (running && is_event && !pin_fall) |=> $stable(cnt_ff))
    else $error("event counter moved without edge");

  pin_inv_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (O_PWM_N == !ff_ff) && (O_PULSE_N == O_PWM_N))
    else $error("pin not inverse of flip-flop");

  pwm_ovf_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (step && is_pwm && ovf) |=> (O_IRQ && ff_ff != $past(ff_ff)))
    else $error("pwm overflow did not toggle");

  stop_hold_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (!running && !wr_ctrl) |=> $stable(ff_ff))
    else $error("output moved while stopped");

  // The write that stops the timer must leave the output level alone.
  stop_write_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (wr_ctrl && running && !ctrl_starts && !step) |=> $stable(ff_ff))
    else $error("stop write changed the output");

  duty_buf_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (is_pwm && running && !clr_evt && !wr_ctrl) |=> $stable(duty_act_ff))
    else $error("duty changed mid period");

  // Outside a PWM run the active duty tracks the written one next cycle.
  duty_follow_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    !(is_pwm && running) |=> duty_act_ff == $past(duty_wr_ff))
    else $error("duty copy did not follow while stopped");

  period_now_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    wr_phi |=> period_ff[15:8] == $past(bus.wdata))
    else $error("period write did not act at once");

  tick_only_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (running && !use_ext && !pre_wrap) |=> $stable(cnt_ff))
    else $error("counter moved between prescaler ticks");

  warm_cmp_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (step && is_warm && cnt_ff[15:8] == period_ff[15:8]) |=>
    cnt_ff == 16'h0000)
    else $error("warm-up upper byte miss");

  duty_read_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (bus.re && bus.addr == ct16_pkg::ADDR_DUTY_LO && is_pwm && running)
    |=> O_RDATA == $past(duty_act_ff[7:0]))
    else $error("duty read not active value");

  pulse_gen_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (step && is_pulse && duty_hit && !per_hit) |=> ff_ff != $past(ff_ff))
    else $error("pulse duty match did not toggle");

  cov_pwm_c:   cover property (@(posedge I_CLK) tog_clr && is_pwm);
  cov_pulse_c: cover property (@(posedge I_CLK) tog_duty && is_pulse);
  cov_event_c: cover property (@(posedge I_CLK) clr_evt && is_event);
  cov_warm_c:  cover property (@(posedge I_CLK) clr_evt && is_warm);
  cov_init_c:  cover property (@(posedge I_CLK) ff_init);

endmodule

`default_nettype wire

// >>> testbench/ct16_src.sv
/*
 * Pulse source model for the event input pin of the cascaded timer.
 * Assumes it shares the timer clock and is enabled by the bench.
 */
`timescale 1ns/10ps
`default_nettype none
module ct16_src (
  // Clock and reset.
  input  wire logic I_CLK,
  input  wire logic I_ARST_N,
  // Enable from the bench.
  input  wire logic i_en,
  // Pin and a one-cycle marker of each falling edge.
  output logic      o_pin,
  output logic      o_fall
);
  logic [1:0] ph_ff;
  // Each level stands two cycles and whole pulses finish; idle is high.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) ph_ff <= 2'h0;
    else if (i_en || ph_ff != 2'h0) ph_ff <= ph_ff + 2'h1;
  end
  assign o_pin  = ~ph_ff[1];
  assign o_fall = (ph_ff == 2'h2);
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
/*
 * Bench for the cascaded timer: register reads checked through a queue,
 * event, PWM and pulse runs fed by the pulse source model, PWM and warm-up runs on the internal tick.
 * Assumes the package and the source model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        we = 1'b0;
  logic        re = 1'b0;
  logic        re_d = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic        pwm_n, pulse_n, irq, pin, fall;
  logic        en = 1'b0;
  logic        pulse_q = 1'b1;
  logic [7:0]  expq[$];
  logic [31:0] seed = 32'had45c87d;
  int          fails = 0, compares = 0, irqs = 0, falls = 0, lows = 0;
  int          i0, n;

  ct16_timer i_dut (.I_CLK(clk), .I_ARST_N(arst_n), .I_WE(we), .I_RE(re),
    .I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata), .I_EVENT_PIN(pin),
    .O_PWM_N(pwm_n), .O_PULSE_N(pulse_n), .O_IRQ(irq));
  ct16_src i_src (.I_CLK(clk), .I_ARST_N(arst_n), .i_en(en), .o_pin(pin),
    .o_fall(fall));

  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask

  // Pairs are written low byte first, then high byte.
  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 4'h1, d[15:8]);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    expq.push_back(e);
    @(posedge clk);
    re <= 1'b0;
  endtask

  // Pulses the asynchronous reset in mid-run; called right after an edge.
  task automatic reboot;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
  endtask

  task automatic pulses(input int k);
    int t;
    t = falls + k;
    @(posedge clk);
    en <= 1'b1;
    while (falls < t) @(posedge clk);
    en <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Read data are checked in the cycle after the strobe; they hold until the next read.
  always @(posedge clk) begin
    if (re_d) chk(16'(rdata), 16'(expq.pop_front()));
    re_d <= re;
    if (irq === 1'b1) irqs <= irqs + 1;
    if (fall === 1'b1) falls <= falls + 1;
    if (pulse_q === 1'b1 && pulse_n === 1'b0) lows <= lows + 1;
    pulse_q <= pulse_n;
  end

  initial begin
    #200000;
    fails++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    chk(16'(pwm_n), 16'h1);
    for (int a = 0; a < 9; a++) rd(4'(a), (a < 4) ? 8'hff : 8'h00);
    wr(4'h9, 8'h5a);
    rd(4'h9, 8'h00);
    // Event counting: period 2 gives one clear per three falls.
    wr16(ct16_pkg::ADDR_PERIOD_LO, 16'h0002);
    i0 = irqs;
    wr(ct16_pkg::ADDR_CTRL, 8'h08);
    pulses(9);
    chk(16'(irqs - i0), 16'h3);
    rd(ct16_pkg::ADDR_CNT_LO, 8'h00);
    pulses(1);
    rd(ct16_pkg::ADDR_CNT_LO, 8'h01);
    chk(16'(pwm_n), 16'h1);
    wr(ct16_pkg::ADDR_CTRL, 8'h00);
    // Pins are watched as driven; the port latch sits outside.
    // PWM from the pin: duty match toggles, duty buffered in run.
    wr16(ct16_pkg::ADDR_DUTY_LO, 16'h0003);
    rd(ct16_pkg::ADDR_DUTY_LO, 8'h03);
    wr(ct16_pkg::ADDR_CTRL, 8'h09);
    pulses(5);
    chk(16'(pwm_n), 16'h0);
    seed = lfsr(seed);
    wr16(ct16_pkg::ADDR_DUTY_LO, seed[15:0]);
    rd(ct16_pkg::ADDR_DUTY_LO, 8'h03);
    rd(ct16_pkg::ADDR_DUTY_HI, 8'h00);
    wr(ct16_pkg::ADDR_CTRL, 8'h01);
    chk(16'(pwm_n), 16'h0);
    rd(ct16_pkg::ADDR_DUTY_LO, seed[7:0]);
    wr(ct16_pkg::ADDR_CTRL, 8'h01);
    @(posedge clk);
    chk(16'(pwm_n), 16'h1);
    wr(ct16_pkg::ADDR_CTRL, 8'h81);
    @(posedge clk);
    chk(16'(pwm_n), 16'h0);
    // The counter keeps its value across a stop, so a reset clears it.
    reboot();
    chk(16'(pwm_n), 16'h1);
    rd(ct16_pkg::ADDR_PERIOD_HI, 8'hff);
    // PWM from the internal tick, one step per eight clocks.
    wr16(ct16_pkg::ADDR_DUTY_LO, 16'h0002);
    wr(ct16_pkg::ADDR_CTRL, 8'h19);
    repeat (8) @(posedge clk);
    chk(16'(pwm_n), 16'h1);
    repeat (32) @(posedge clk);
    chk(16'(pwm_n), 16'h0);
    wr(ct16_pkg::ADDR_CTRL, 8'h11);
    chk(16'(pwm_n), 16'h0);
    reboot();
    wr(ct16_pkg::ADDR_CTRL, 8'h02);
    // Pulse mode: duty 1, period 3, four steps per clear.
    wr16(ct16_pkg::ADDR_PERIOD_LO, 16'h0003);
    wr16(ct16_pkg::ADDR_DUTY_LO, 16'h0001);
    i0 = irqs;
    n = lows;
    wr(ct16_pkg::ADDR_CTRL, 8'h0a);
    pulses(8);
    chk(16'(irqs - i0), 16'h2);
    chk(16'(lows - n), 16'h2);
    chk(16'(pulse_n), 16'h1);
    wr(ct16_pkg::ADDR_CTRL, 8'h02);
    // Warm-up: period 0x01ff matches on the upper byte alone.
    wr16(ct16_pkg::ADDR_PERIOD_LO, 16'h01ff);
    i0 = irqs;
    wr(ct16_pkg::ADDR_CTRL, 8'h1b);
    n = 0;
    while (irqs == i0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    chk(16'(n >= 2000 && n <= 2400), 16'h1);
    chk(16'(pwm_n), 16'h1);
    wr(ct16_pkg::ADDR_CTRL, 8'h03);
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule
`default_nettype wire
